//--- include/tci_pkg.sv
// Constants and types shared by the touch controller two-wire slave port.
package tci_pkg;

  // -----------------------------------------------------------------
  // Bus rates and the system clock
  // -----------------------------------------------------------------
  localparam int STD_KBPS = 100;
  localparam int FAST_KBPS = 400;
  localparam int CLK_MHZ = 125;
  // Shortest SCL half period in system clocks; the synchronisers need far fewer.
  localparam int MIN_HALF_CYC = (CLK_MHZ * 1000) / (2 * FAST_KBPS);

  // -----------------------------------------------------------------
  // Addresses
  // -----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h58;
  localparam logic [9:0] SLAVE_ADDR10 = 10'h058;
  localparam logic [4:0] TENBIT_PREFIX = 5'h1e;
  localparam logic [7:0] GENCALL_BYTE = 8'h00;
  localparam logic [7:0] TOUCH_FIFO_ADDR = 8'h18;
  localparam logic [7:0] PWM_PORT_ADDR = 8'hff;

  // -----------------------------------------------------------------
  // Reset values and counts
  // -----------------------------------------------------------------
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam int FIFO_DEPTH = 16;

  // Protocol states, Gray coded along address, pointer and data.
  typedef enum logic [2:0] {
    TCI_IDLE   = 3'h0,
    TCI_ADDR   = 3'h1,
    TCI_ADDR2  = 3'h3,
    TCI_REGPTR = 3'h2,
    TCI_WRDATA = 3'h6,
    TCI_RDDATA = 3'h7,
    TCI_GCALL  = 3'h5,
    TCI_IGNORE = 3'h4
  } tci_state_t;

endpackage

//--- include/tci_stream_if.sv
// Valid/ready stream carrying register writes between the port and its buffer.
interface tci_stream_if #(
  parameter int WIDTH = 16
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- design/tci_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
module tci_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  tci_stream_if.snk in_port,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_idx, next_wr_idx, rd_idx, next_rd_idx;
  logic [AW:0] count, next_count;
  logic next_out_valid;
  logic push, pop;

  // -----------------------------------------------------------------
  // Handshakes
  // -----------------------------------------------------------------
  // Ready drops only when full, so the port sees back-pressure and refuses bytes.
  assign in_port.ready = (count != (AW+1)'(DEPTH));
  assign push = in_port.valid && in_port.ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_idx];

  // Pointer and occupancy update.
  always_comb begin
    next_wr_idx = push ? wr_idx + 1'b1 : wr_idx;
    next_rd_idx = pop ? rd_idx + 1'b1 : rd_idx;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_out_valid = (next_count != '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
      out_valid <= 1'b0;
    end else begin
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count <= next_count;
      out_valid <= next_out_valid;
    end
  end

  // -----------------------------------------------------------------
  // Storage, one entry per loop pass
  // -----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      next_mem[i] = (push && (wr_idx == AW'(i))) ? in_port.data : mem[i];
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem[i] <= '0;
      end else begin
        mem[i] <= next_mem[i];
      end
    end
  end
endmodule

//--- design/tci_slave_port.sv
// Two-wire slave port giving a bus master access to the 8-bit register space.
module tci_slave_port
  import tci_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic [7:0] rd_addr,
  output logic rd_strobe,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  // -----------------------------------------------------------------
  // Link domain: bit capture on the master's clock
  // -----------------------------------------------------------------
  logic bit_val, bit_tog;

  // Every rising SCL edge captures SDA and flips a toggle for the clk side.
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      bit_val <= 1'b0;
      bit_tog <= 1'b0;
    end else begin
      bit_val <= sda_i;
      bit_tog <= ~bit_tog;
    end
  end

  // -----------------------------------------------------------------
  // Crossing into the system clock
  // -----------------------------------------------------------------
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, tog_m, tog_s, tog_p;
  logic start_det, stop_det, fall_det, bit_evt;

  // Two flops for each pin and for the toggle; the third flop gives edges.
  // The captured bit is read only after its toggle arrives, so it is stable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
      {tog_m, tog_s, tog_p} <= 3'h0;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      {tog_m, tog_s, tog_p} <= {bit_tog, tog_m, tog_s};
    end
  end

  // Fast mode half periods span well over a hundred clocks, so sampling is exact.
  assign start_det = scl_s && scl_p && sda_p && !sda_s;
  assign stop_det = scl_s && scl_p && !sda_p && sda_s;
  assign fall_det = scl_p && !scl_s;
  assign bit_evt = tog_s ^ tog_p;

  // -----------------------------------------------------------------
  // Write buffer
  // -----------------------------------------------------------------
  tci_stream_if #(.WIDTH(16)) wr_if ();

  tci_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_port(wr_if.snk),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );

  // -----------------------------------------------------------------
  // Protocol engine
  // -----------------------------------------------------------------
  tci_state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] sh, next_sh, ptr, next_ptr, txbyte, next_txbyte;
  logic [7:0] push_data, next_push_data, rx_byte;
  logic ack_pend, next_ack_pend, ten_hit, next_ten_hit;
  logic push, next_push, next_rd_strobe, next_sda_oe_n;

  // The FIFO and PWM command ports keep the pointer fixed between bytes.
  function automatic logic [7:0] advance(input logic [7:0] p);
    if (p == TOUCH_FIFO_ADDR || p == PWM_PORT_ADDR) begin
      return p;
    end
    return p + 8'h01;
  endfunction

  assign rx_byte = {sh[6:0], bit_val};
  assign wr_if.valid = push;
  assign wr_if.data = {ptr, push_data};
  assign rd_addr = ptr;

  // Next-state logic: conditions first, then bits, then SCL falls.
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_ptr = ptr;
    next_txbyte = rd_strobe ? rd_data : txbyte;
    next_push_data = push_data;
    next_ack_pend = ack_pend;
    next_ten_hit = ten_hit;
    next_push = 1'b0;
    next_rd_strobe = 1'b0;
    next_sda_oe_n = sda_oe_n;
    if (stop_det) begin
      // A stop drops every transfer, so no later byte reaches a register.
      next_state = TCI_IDLE;
      next_ten_hit = 1'b0;
      next_ack_pend = 1'b0;
      next_sda_oe_n = 1'b1;
    end else if (start_det) begin
      // A repeated start keeps the 10-bit match for the read that follows.
      next_state = TCI_ADDR;
      next_bitcnt = 4'h0;
      next_ack_pend = 1'b0;
      next_sda_oe_n = 1'b1;
    end else if (bit_evt && state != TCI_IDLE) begin
      if (bitcnt != ACK_SLOT) begin
        next_sh = rx_byte;
        next_bitcnt = bitcnt + 4'h1;
        if (bitcnt == LAST_DATA_BIT) begin
          next_ack_pend = 1'b1;
          case (state)
            TCI_ADDR: begin
              if (rx_byte[7:1] == SLAVE_ADDR) begin
                // Low bit set means read, clear means write.
                next_state = rx_byte[0] ? TCI_RDDATA : TCI_REGPTR;
                next_rd_strobe = rx_byte[0];
              end else if (rx_byte[7:3] == TENBIT_PREFIX &&
                           rx_byte[2:1] == SLAVE_ADDR10[9:8]) begin
                if (!rx_byte[0]) begin
                  next_state = TCI_ADDR2;
                end else if (ten_hit) begin
                  next_state = TCI_RDDATA;
                  next_rd_strobe = 1'b1;
                end else begin
                  next_state = TCI_IGNORE;
                  next_ack_pend = 1'b0;
                end
              end else if (rx_byte == GENCALL_BYTE) begin
                next_state = TCI_GCALL;
              end else begin
                next_state = TCI_IGNORE;
                next_ack_pend = 1'b0;
              end
            end
            TCI_ADDR2: begin
              if (rx_byte == SLAVE_ADDR10[7:0]) begin
                next_state = TCI_REGPTR;
                next_ten_hit = 1'b1;
              end else begin
                next_state = TCI_IGNORE;
                next_ack_pend = 1'b0;
              end
            end
            TCI_REGPTR: begin
              next_ptr = rx_byte;
              next_state = TCI_WRDATA;
            end
            TCI_WRDATA: begin
              // A full buffer refuses the byte with a not-acknowledge.
              if (wr_if.ready) begin
                next_push = 1'b1;
                next_push_data = rx_byte;
              end else begin
                next_ack_pend = 1'b0;
              end
            end
            TCI_GCALL: begin
              next_ack_pend = 1'b1;
            end
            default: begin
              next_ack_pend = 1'b0;
            end
          endcase
        end
      end else begin
        // Ninth bit: in a read it is the master's answer after each data byte.
        next_bitcnt = 4'h0;
        if (state == TCI_RDDATA) begin
          if (!sda_oe_n) begin
            // Our own address acknowledge; the first byte was fetched at the match.
            // Advancing here would skip the byte the master pointed at.
            next_ptr = ptr;
          end else if (bit_val) begin
            next_state = TCI_IGNORE;
          end else begin
            next_ptr = advance(ptr);
            next_rd_strobe = 1'b1;
          end
        end
      end
    end else if (fall_det && state != TCI_IDLE) begin
      // SDA changes only after SCL has fallen.
      if (state == TCI_IGNORE) begin
        next_sda_oe_n = 1'b1;
      end else if (bitcnt == ACK_SLOT) begin
        next_sda_oe_n = !ack_pend;
        next_ack_pend = 1'b0;
      end else if (state == TCI_RDDATA) begin
        next_sda_oe_n = txbyte[3'h7 - bitcnt[2:0]];
      end else begin
        next_sda_oe_n = 1'b1;
      end
    end
    if (push) begin
      next_ptr = advance(ptr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TCI_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      ptr <= PTR_RESET;
      txbyte <= 8'h00;
      push_data <= 8'h00;
      ack_pend <= 1'b0;
      ten_hit <= 1'b0;
      push <= 1'b0;
      rd_strobe <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      ptr <= next_ptr;
      txbyte <= next_txbyte;
      push_data <= next_push_data;
      ack_pend <= next_ack_pend;
      ten_hit <= next_ten_hit;
      push <= next_push;
      rd_strobe <= next_rd_strobe;
      sda_oe_n <= next_sda_oe_n;
      sda_o <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  start_resets_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_det && !stop_det |=> state == TCI_ADDR && bitcnt == 4'h0 && sda_oe_n)
    else $error("start did not restart address phase");

  stop_idles_a: assert property (@(posedge clk) disable iff (!rst_n)
    stop_det |=> state == TCI_IDLE ##1 !push)
    else $error("stop did not return to idle");

  idle_no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCI_IDLE && $past(state) == TCI_IDLE |-> !push)
    else $error("write pushed after stop");

  ack_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    fall_det && ack_pend && bitcnt == ACK_SLOT && !stop_det && !start_det
    && state != TCI_IGNORE |=> !sda_oe_n)
    else $error("acknowledge not driven on ninth bit");

  mismatch_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCI_IGNORE && $past(state) == TCI_IGNORE |=> sda_oe_n || start_det)
    else $error("deselected port drove the bus");

  read_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    bit_evt && state == TCI_ADDR && bitcnt == LAST_DATA_BIT
    && rx_byte == {SLAVE_ADDR, 1'b1} && !start_det && !stop_det
    |=> state == TCI_RDDATA && rd_strobe ##1 txbyte == $past(rd_data))
    else $error("read address not decoded as read");

  addr_ack_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    bit_evt && state == TCI_RDDATA && bitcnt == ACK_SLOT && !sda_oe_n
    && !start_det && !stop_det |=> ptr == $past(ptr) && !rd_strobe)
    else $error("pointer moved on the read address acknowledge");

  noinc_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    push && (ptr == TOUCH_FIFO_ADDR || ptr == PWM_PORT_ADDR) |=> ptr == $past(ptr))
    else $error("pointer moved on a fixed port");

  inc_adv_a: assert property (@(posedge clk) disable iff (!rst_n)
    push && ptr != TOUCH_FIFO_ADDR && ptr != PWM_PORT_ADDR
    |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance after write");

  gcall_discard_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCI_GCALL |=> !push)
    else $error("general call data reached registers");

  sample_edge_a: assert property (@(posedge scl) disable iff (!rst_n)
    1'b1 |=> bit_tog != $past(bit_tog) && bit_val == $past(sda_i))
    else $error("SDA not captured on SCL rise");

endmodule

//--- verif/tci_reg_model.sv
// Register-space model serving reads and draining the port's write buffer.
module tci_reg_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] rd_addr,
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;

  logic slow;
  logic [15:0] got[$];

  // Data is valid only in the strobe cycle; otherwise the inverse shows, to catch late sampling.
  assign rd_data = rd_strobe ? (rd_addr ^ 8'h5a) : ~(rd_addr ^ 8'h5a);
  // Accept on every other cycle so the buffer sees back-pressure even when not stalled.
  assign wr_ready = !stall && slow;

  // Record every accepted write in arrival order.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow <= 1'b0;
    end else begin
      slow <= !slow;
      if (wr_valid && wr_ready) begin
        got.push_back({wr_addr, wr_data});
      end
    end
  end
endmodule

//--- verif/tci_slave_port_tb.sv
// Self-checking testbench for the two-wire slave port.
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t %s", $time, m); end end

module tci_slave_port_tb
  import tci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic stall = 1'b0;
  logic sda_o;
  logic sda_oe_n;
  logic sda_w;
  logic [7:0] rd_addr;
  logic rd_strobe;
  logic [7:0] rd_data;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] p;
  logic [7:0] d;
  logic [15:0] q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Wired-AND with a pull-up: either party may pull the line low.
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  tci_slave_port #(.FIFO_WORDS(4)) uut (
    .clk(clk),
    .rst_n(rst_n),
    .scl(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .rd_addr(rd_addr),
    .rd_strobe(rd_strobe),
    .rd_data(rd_data),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  tci_reg_model model (
    .clk(clk),
    .rst_n(rst_n),
    .rd_addr(rd_addr),
    .rd_strobe(rd_strobe),
    .rd_data(rd_data),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .stall(stall)
  );

  // 125 MHz system clock.
  initial begin
    forever #4 clk = ~clk;
  end

  // -----------------------------------------------------------------
  // Bus master tasks; SCL runs at 160 ns only while a task runs
  // -----------------------------------------------------------------
  // One bit: data changes while SCL is low, sampled in the middle of the high phase.
  task automatic bt(input logic b, output logic r);
    sda_m = b;
    #40;
    scl = 1'b1;
    #40;
    r = sda_w;
    #40;
    scl = 1'b0;
    #40;
  endtask

  // Start or repeated start: SDA falls while SCL is high.
  task automatic sr();
    sda_m = 1'b1;
    #40;
    scl = 1'b1;
    #80;
    sda_m = 1'b0;
    #80;
    scl = 1'b0;
    #40;
  endtask

  // Stop: SDA rises while SCL is high; the clock then stands still.
  task automatic sp();
    sda_m = 1'b0;
    #40;
    scl = 1'b1;
    #80;
    sda_m = 1'b1;
    #80;
  endtask

  // Send a byte MSB first and check the slave's answer in the ninth slot.
  task automatic wb(input logic [7:0] b, input logic e);
    logic r;
    for (int k = 7; k >= 0; k--) bt(b[k], r);
    bt(1'b1, r);
    `CHK(r, !e, "ack level")
  endtask

  // Receive a byte; the slave must leave the line free for our ack or nack.
  task automatic rb(input logic last, output logic [7:0] v);
    logic r;
    for (int k = 0; k < 8; k++) begin
      bt(1'b1, r);
      v = {v[6:0], r};
    end
    bt(last, r);
    `CHK(r, last, "ack slot not released")
  endtask

  // Write n random bytes from pointer pt; bytes from index lim on must be refused.
  task automatic wseq(input logic [7:0] pt, input int n, input int lim, input bit inc);
    logic [7:0] v;
    sr();
    wb(8'hb0, 1'b1);
    wb(pt, 1'b1);
    for (int k = 0; k < n; k++) begin
      v = 8'($urandom);
      if (k < lim) q.push_back({inc ? pt + 8'(k) : pt, v});
      wb(v, k < lim);
    end
    sp();
  endtask

  // Pointer write, repeated start, then n reads ending with a nack.
  task automatic rseq(input logic [7:0] pt, input int n, input bit inc);
    logic [7:0] v;
    sr();
    wb(8'hb0, 1'b1);
    wb(pt, 1'b1);
    sr();
    wb(8'hb1, 1'b1);
    for (int k = 0; k < n; k++) begin
      rb(k == n - 1, v);
      `CHK(v, (inc ? pt + 8'(k) : pt) ^ 8'h5a, "read data")
    end
    sp();
  endtask

  // Let the buffer empty, compare what reached the register side, realign off-edge.
  task automatic drain(input string nm);
    repeat (40) @(posedge clk);
    `CHK(model.got.size(), q.size(), "write count")
    for (int k = 0; k < q.size() && k < model.got.size(); k++) begin
      `CHK(model.got[k], q[k], "write entry")
    end
    model.got.delete();
    q.delete();
    $display("test %s done", nm);
    @(negedge clk);
    #3;
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cut a hang short; the whole run needs far fewer cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      print_verdict();
    end
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2c41));
    // A real falling edge is needed: the link flops see no SCL edge during reset.
    #1;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    #3;
    repeat (2) begin
      p = 8'h20 + 8'($urandom_range(0, 15));
      wseq(p, 3, 3, 1'b1);
      drain("write");
    end
    wseq(PWM_PORT_ADDR, 2, 2, 1'b0);
    drain("pwm");
    // Bytes clocked after a stop without a new start must be ignored.
    wb(8'hb0, 1'b0);
    wb(8'h10, 1'b0);
    sp();
    drain("nostart");
    // Hold the register side off so the buffer fills and refuses.
    stall = 1'b1;
    wseq(8'h30, 5, 4, 1'b1);
    stall = 1'b0;
    drain("fill");
    repeat (2) begin
      p = 8'h40 + 8'($urandom_range(0, 63));
      rseq(p, 3, 1'b1);
    end
    rseq(TOUCH_FIFO_ADDR, 3, 1'b0);
    drain("read");
    sr();
    wb(8'hb2, 1'b0);
    wb(8'h21, 1'b0);
    sp();
    drain("other address");
    sr();
    wb(8'h00, 1'b1);
    wb(8'h5c, 1'b1);
    sp();
    drain("general call");
    d = 8'($urandom);
    q.push_back({8'h44, d});
    sr();
    wb(8'hf0, 1'b1);
    wb(8'h58, 1'b1);
    wb(8'h44, 1'b1);
    wb(d, 1'b1);
    sp();
    drain("ten bit");
    print_verdict();
  end
endmodule
